// File: rtl/adaptive_equalizer_search.sv
// Gain search controller for one serial receive port with its register file.
// Assumes a register port already decoded from the serial management bus, and
// lock and error indications from the analog receiver, asynchronous to core_clk.
`timescale 1ns/1ps
`include "eq_search_cfg.svh"
module adaptive_equalizer_search
    import eq_search_pkg::*;
#(
    parameter int GAIN_W   = 4,
    parameter int DWELL_W  = 24,
    parameter int DWELL_BASE = `DWELL_BASE_CYC
) (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              logic_soft_reset,
    input  wire reg_req_s          reg_req,
    output logic [7:0]             reg_rdata,
    output logic                   reg_rvalid,
    input  wire logic              cdr_lock_async,
    input  wire link_err_s         link_err_async,
    input  wire logic              partner_compatible,
    output logic [GAIN_W-1:0]      gain_setting,
    output logic                   search_locked
);
    logic [7:0]         err_sel_q;
    logic [7:0]         ctrl_q;
    logic [7:0]         range_q;
    search_state_e      state_q;
    logic [GAIN_W-1:0]  gain_q;
    logic [DWELL_W-1:0] dwell_cnt_q;
    logic [DWELL_W-1:0] dwell_len;
    logic               first_lock_done_q;
    logic               restart_req;
    logic [3:0]         sync_vec;
    logic               lock_s;
    link_err_s          err_s;
    logic               err_over;
    logic               err_check_on;
    logic               window_open;
    logic [GAIN_W-1:0]  start_gain;
    logic [GAIN_W-1:0]  ceiling;
    logic [GAIN_W-1:0]  next_gain;
    logic               first_lock_restart;
    logic               dwell_done;
    logic               wr_ctrl;

    eq_input_sync #(
        .WIDTH(4)
    ) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in ({cdr_lock_async, link_err_async}),
        .sync_out (sync_vec)
    );

    assign lock_s = sync_vec[3];
    assign err_s  = link_err_s'(sync_vec[2:0]);

    // Register writes.
    assign wr_ctrl = reg_req.wr_en && reg_req.addr == `REG_SEARCH_CTRL;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            err_sel_q <= `ERRSEL_RESET;
            ctrl_q    <= `CTRL_RESET;
            range_q   <= `RANGE_RESET;
        end else begin
            if (reg_req.wr_en && reg_req.addr == `REG_ERR_SRC_SEL) begin
                err_sel_q <= reg_req.wdata;
            end
            if (wr_ctrl) begin
                // The restart bit self-clears; it is acted on as a one-shot.
                ctrl_q <= reg_req.wdata & ~(8'h01 << `CTRL_RESTART_BIT);
            end
            if (reg_req.wr_en && reg_req.addr == `REG_GAIN_RANGE) begin
                range_q <= reg_req.wdata;
            end
        end
    end

    // Register reads, answered the cycle after the request.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd_en;
            if (reg_req.rd_en) begin
                case (reg_req.addr)
                    `REG_ERR_SRC_SEL:   reg_rdata <= err_sel_q;
                    `REG_SEARCH_CTRL:   reg_rdata <= ctrl_q;
                    // The hold bit is taken from the state so it pairs with the same gain.
                    `REG_ADAPTED_VALUE: reg_rdata <= {state_q == st_hold, 7'(gain_q)};
                    `REG_GAIN_RANGE:    reg_rdata <= range_q;
                    default:            reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Derived controls.
    assign ceiling = GAIN_W'(range_q[`RANGE_CEIL_MSB:`RANGE_CEIL_LSB]);
    // The floor value, capped at the ceiling, seeds each restart (reset seeds 0); it bounds wraps only when enabled.
    assign start_gain = GAIN_W'(range_q[`RANGE_FLOOR_MSB:`RANGE_FLOOR_LSB]);
    assign dwell_len  = DWELL_W'(DWELL_BASE) << ctrl_q[`CTRL_DWELL_MSB:`CTRL_DWELL_LSB];
    assign err_check_on = ctrl_q[`CTRL_ERRCHK_BIT];
    assign window_open  = state_q == st_dwell && dwell_cnt_q >= (dwell_len >> 1);
    assign dwell_done   = dwell_cnt_q >= dwell_len - DWELL_W'(1);

    always_comb begin
        // Next step ascends by one, wrapping at the ceiling.
        if (gain_q >= ceiling) begin
            next_gain = ctrl_q[`CTRL_FLOOR_EN_BIT] ? start_gain : '0;
        end else begin
            next_gain = gain_q + GAIN_W'(1);
        end
        if (next_gain > ceiling) begin
            next_gain = ceiling;
        end
    end

    assign first_lock_restart = lock_s && !first_lock_done_q && partner_compatible
                                && ctrl_q[`CTRL_FIRSTLOCK_BIT];
    assign restart_req = logic_soft_reset
                         || (wr_ctrl && reg_req.wdata[`CTRL_RESTART_BIT])
                         || first_lock_restart;

    eq_error_counter #(
        .CNT_W(8)
    ) u_errcnt (
        .core_clk    (core_clk),
        .reset       (reset),
        .clear       (state_q != st_dwell || restart_req),
        .window_open (window_open),
        .errs        (err_s),
        .select      (err_sel_q[`ERRSEL_PAR_BIT:`ERRSEL_CDR_BIT]),
        .threshold   (err_sel_q[`ERRSEL_THR_MSB:`ERRSEL_THR_LSB]),
        .over        (err_over)
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            first_lock_done_q <= 1'b0;
        end else if (lock_s) begin
            first_lock_done_q <= 1'b1;
        end
    end

    // Search state machine; it runs from reset whether or not a signal is present.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q     <= st_apply;
            gain_q      <= '0;
            dwell_cnt_q <= '0;
        end else if (restart_req) begin
            state_q     <= st_apply;
            gain_q      <= (start_gain > ceiling) ? ceiling : start_gain;
            dwell_cnt_q <= '0;
        end else begin
            case (state_q)
                st_apply: begin
                    dwell_cnt_q <= '0;
                    state_q     <= st_dwell;
                end
                st_dwell: begin
                    if (!dwell_done) begin
                        dwell_cnt_q <= dwell_cnt_q + DWELL_W'(1);
                    end else if (lock_s && !(err_check_on && err_over)) begin
                        state_q <= st_hold;
                    end else begin
                        gain_q  <= next_gain;
                        state_q <= st_apply;
                    end
                end
                st_hold: begin
                    if (!lock_s) begin
                        gain_q  <= next_gain;
                        state_q <= st_apply;
                    end
                end
                default: begin
                    state_q <= st_apply;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            gain_setting  <= '0;
            search_locked <= 1'b0;
        end else begin
            gain_setting  <= gain_q;
            search_locked <= state_q == st_hold;
        end
    end
endmodule

// File: rtl/eq_search_cfg.svh
// Register map, field positions, reset values and timing constants of the gain search block.
// Assumes it is included by its bare name into the package and the modules.
`ifndef EQ_SEARCH_CFG_SVH
`define EQ_SEARCH_CFG_SVH

`define REG_ERR_SRC_SEL      8'h42
`define REG_SEARCH_CTRL      8'hd2
`define REG_ADAPTED_VALUE    8'hd3
`define REG_GAIN_RANGE       8'hd5

// Error source select fields.
`define ERRSEL_CDR_BIT       0
`define ERRSEL_ENC_BIT       1
`define ERRSEL_PAR_BIT       2
`define ERRSEL_THR_LSB       4
`define ERRSEL_THR_MSB       7
`define ERRSEL_RESET         8'h17

// Search control fields.
`define CTRL_RESTART_BIT     0
`define CTRL_FIRSTLOCK_BIT   1
`define CTRL_FLOOR_EN_BIT    2
`define CTRL_ERRCHK_BIT      3
`define CTRL_DWELL_LSB       4
`define CTRL_DWELL_MSB       6
`define CTRL_RESET           8'h3a

// Gain range fields: ceiling high nibble, floor low nibble.
`define RANGE_FLOOR_LSB      0
`define RANGE_FLOOR_MSB      3
`define RANGE_CEIL_LSB       4
`define RANGE_CEIL_MSB       7
`define RANGE_RESET          8'hf0

// Dwell base time; the field selects base shifted left by its value.
`define DWELL_BASE_NS        327500
`define CLK_PERIOD_NS        20
`define DWELL_BASE_CYC       ((`DWELL_BASE_NS) / (`CLK_PERIOD_NS))
`define DWELL_DEFAULT_SEL    3'h3

`endif

// File: rtl/eq_search_pkg.sv
// Types shared by the gain search block.
// Assumes eq_search_cfg.svh is on the include path.
package eq_search_pkg;
`include "eq_search_cfg.svh"

    typedef enum logic [1:0] {
        st_apply,
        st_dwell,
        st_hold
    } search_state_e;

    typedef struct packed {
        logic       cdr_err;
        logic       enc_err;
        logic       par_err;
    } link_err_s;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
endpackage

// File: rtl/eq_input_sync.sv
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes the inputs come from analog or recovered-clock logic.
`timescale 1ns/1ps
module eq_input_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// File: rtl/eq_error_counter.sv
// Counts selected link errors over a window and flags excess.
// Assumes error inputs are already synchronised to core_clk.
`timescale 1ns/1ps
`include "eq_search_cfg.svh"
module eq_error_counter
    import eq_search_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       clear,
    input  wire logic       window_open,
    input  wire link_err_s  errs,
    input  wire logic [2:0] select,
    input  wire logic [3:0] threshold,
    output logic            over
);
    logic [CNT_W-1:0] count_q;
    logic [1:0]       hits;

    always_comb begin
        hits = 2'(errs.cdr_err & select[`ERRSEL_CDR_BIT])
             + 2'(errs.enc_err & select[`ERRSEL_ENC_BIT])
             + 2'(errs.par_err & select[`ERRSEL_PAR_BIT]);
    end

    always_ff @(posedge core_clk) begin
        if (reset || clear) begin
            count_q <= '0;
        end else if (window_open && count_q < {CNT_W{1'b1}} - CNT_W'(3)) begin
            count_q <= count_q + CNT_W'(hits);
        end
    end

    assign over = count_q > CNT_W'(threshold);
endmodule

// File: testbench/eq_search_assertions.sv
// Port checks for the gain search block, bound to its top module.
// Assumes the bench keeps the floor at or below the ceiling.
`timescale 1ns/1ps
module eq_search_assertions
    import eq_search_pkg::*;
#(
    parameter int GAIN_W = 4
) (
    input wire logic              core_clk,
    input wire logic              reset,
    input wire logic              logic_soft_reset,
    input wire reg_req_s          reg_req,
    input wire logic [7:0]        reg_rdata,
    input wire logic              reg_rvalid,
    input wire logic              cdr_lock_async,
    input wire logic [GAIN_W-1:0] gain_setting,
    input wire logic              search_locked
);
    logic [3:0] floor_q;
    logic [3:0] ceil_q;
    logic       restart_w;
    assign restart_w = logic_soft_reset
        || (reg_req.wr_en && reg_req.addr == 8'hd2 && reg_req.wdata[0]);
    // Range is mirrored from writes so the checks need no internal probes.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            floor_q <= 4'h0;
            ceil_q  <= 4'hf;
        end else if (reg_req.wr_en && reg_req.addr == 8'hd5) begin
            floor_q <= reg_req.wdata[3:0];
            ceil_q  <= reg_req.wdata[7:4];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    rd_answer_a: assert property (reg_req.rd_en |=> reg_rvalid)
        else $error("read not answered");
    rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_req.rd_en))
        else $error("answer without read");
    status_read_a: assert property (
        reg_req.rd_en && reg_req.addr == 8'hd3 |=>
        reg_rdata == {search_locked, 3'h0, gain_setting}) else $error("status mismatch");
    hold_steady_a: assert property (
        search_locked && $past(search_locked) |-> $stable(gain_setting))
        else $error("gain moved while held");
    dwell_first_a: assert property (
        $rose(search_locked) |-> $past(gain_setting, 20) == gain_setting
        && $past(cdr_lock_async, 4)) else $error("hold without dwell");
    unlock_leave_a: assert property (
        (search_locked && !cdr_lock_async) [*3] |=> ##[0:4] !search_locked)
        else $error("hold kept after lock loss");
    restart_floor_a: assert property (
        restart_w |-> ##2 !search_locked && gain_setting ==
        (($past(floor_q, 2) > $past(ceil_q, 2)) ? $past(ceil_q, 2) : $past(floor_q, 2)))
        else $error("restart not at floor");
    ceiling_cap_a: assert property (
        $changed(gain_setting) |-> gain_setting <= $past(ceil_q, 2))
        else $error("gain above ceiling");
    step_up_a: assert property (
        $changed(gain_setting) && !$past(restart_w, 2) |-> gain_setting == $past(floor_q, 2)
        || gain_setting == 0 || gain_setting == $past(gain_setting) + 1'b1)
        else $error("gain step not ascending");
    cover property ($rose(search_locked));
    cover property (restart_w && search_locked);
    cover property ($changed(gain_setting) && $past(gain_setting) == ceil_q);
endmodule
bind adaptive_equalizer_search eq_search_assertions #(.GAIN_W(GAIN_W)) u_eq_search_assertions (
    .core_clk, .reset, .logic_soft_reset, .reg_req, .reg_rdata, .reg_rvalid,
    .cdr_lock_async, .gain_setting, .search_locked);

// File: testbench/eq_rx_model.sv
// Receiver model: recovery locks at one gain only, errors are forced by the bench.
// Assumes the gain comes from the search block; outputs are asynchronous.
`timescale 1ns/1ps
module eq_rx_model
    import eq_search_pkg::*;
(
    input  wire logic       lock_en,
    input  wire logic [3:0] lock_gain,
    input  wire link_err_s  err_force,
    input  wire logic [3:0] gain_setting,
    output logic            cdr_lock_async,
    output link_err_s       link_err_async
);
    initial cdr_lock_async = 1'b0;
    // Lock lags the gain off the clock edge, as the analog path would.
    always @(gain_setting or lock_en or lock_gain) begin
        cdr_lock_async <= #3 lock_en && gain_setting == lock_gain;
    end
    assign link_err_async = err_force;
endmodule

// File: testbench/tb_adaptive_equalizer_search.sv
// Self-checking bench for the gain search block with a receiver model.
// Assumes a 50 MHz core clock and a dwell base shortened to four cycles.
`timescale 1ns/1ps
`include "eq_search_cfg.svh"
module tb_adaptive_equalizer_search;
    import eq_search_pkg::*;
    localparam int DWELL = 4 << 3;
    logic       core_clk;
    logic       reset;
    logic       logic_soft_reset;
    reg_req_s   reg_req;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    logic       cdr_lock_async;
    link_err_s  link_err_async;
    link_err_s  err_force;
    logic       partner_compatible;
    logic [3:0] gain_setting;
    logic       search_locked;
    logic [3:0] lock_gain;
    logic       lock_en;
    logic [3:0] fl;
    logic [3:0] g;
    logic [3:0] eg;
    logic [7:0] rd_q;
    int         n;
    int         bad_count;
    int         samples_checked;
    adaptive_equalizer_search #(.DWELL_BASE(4)) u_adaptive_equalizer_search (
        .core_clk, .reset, .logic_soft_reset, .reg_req, .reg_rdata, .reg_rvalid,
        .cdr_lock_async, .link_err_async, .partner_compatible, .gain_setting, .search_locked);
    eq_rx_model u_eq_rx_model (.lock_en, .lock_gain, .err_force, .gain_setting,
        .cdr_lock_async, .link_err_async);
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Successor of a gain in an unlocked search, wrapping at the ceiling.
    function automatic logic [3:0] exp_next(input logic [3:0] cur, input logic [3:0] lo,
                                            input logic [3:0] hi, input logic fe_on);
        if (cur >= hi) begin
            return fe_on ? lo : 4'h0;
        end
        return cur + 4'h1;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk);
        reg_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk);
        reg_req <= '0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    // Range changes happen under soft reset so no step sees a half-written range.
    task automatic setup(input logic [7:0] range, input logic [7:0] ctrl);
        @(posedge core_clk);
        logic_soft_reset <= 1'b1;
        wr(`REG_GAIN_RANGE, range);
        wr(`REG_SEARCH_CTRL, ctrl);
        logic_soft_reset <= 1'b0;
    endtask
    task automatic drive(input logic en, input logic [3:0] tgt, input link_err_s e);
        @(posedge core_clk);
        lock_en <= en;
        lock_gain <= tgt;
        err_force <= e;
    endtask
    task automatic wait_change(output int k);
        @(negedge core_clk);
        g = gain_setting;
        k = 0;
        while (gain_setting === g && k < 4 * DWELL) begin
            @(negedge core_clk);
            k++;
        end
    endtask
    task automatic wait_lock();
        for (int k = 0; k < 16 * DWELL && search_locked !== 1'b1; k++) @(negedge core_clk);
        check(8'(search_locked), 8'h1);
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #500000;
        bad_count++;
        finish_test();
    end
    initial begin
        reset = 1'b1;
        logic_soft_reset = 1'b0;
        reg_req = '0;
        partner_compatible = 1'b1;
        lock_en = 1'b0;
        lock_gain = 4'h0;
        err_force = '0;
        bad_count = 0;
        samples_checked = 0;
        void'($urandom(78692));
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        rd(`REG_ERR_SRC_SEL, rd_q);
        check(rd_q, `ERRSEL_RESET);
        rd(`REG_SEARCH_CTRL, rd_q);
        check(rd_q, `CTRL_RESET);
        check(8'(rd_q[`CTRL_DWELL_MSB:`CTRL_DWELL_LSB]), 8'(`DWELL_DEFAULT_SEL));
        rd(`REG_GAIN_RANGE, rd_q);
        check(rd_q, `RANGE_RESET);
        wr(`REG_ADAPTED_VALUE, 8'h7f);
        rd(`REG_ADAPTED_VALUE, rd_q);
        check(rd_q, 8'h00);
        wr(8'h77, 8'hff);
        rd(8'h77, rd_q);
        check(rd_q, 8'h00);
        wait_change(n);
        check(8'(n < 4 * DWELL), 8'h1);
        $display("Register and power-up test done");
        for (int fe = 0; fe < 2; fe++) begin
            fl = 4'($urandom_range(1, 3));
            setup({fl + 4'h2, fl}, 8'h30 | 8'(fe << 2));
            repeat (2) @(negedge core_clk);
            check(8'(gain_setting), 8'(fl));
            eg = fl;
            for (int k = 0; k < 7; k++) begin
                eg = exp_next(eg, fl, fl + 4'h2, fe[0]);
                wait_change(n);
                check(8'(gain_setting), 8'(eg));
                if (k > 0) check(8'(n >= DWELL - 1 && n <= DWELL + 2), 8'h1);
            end
        end
        $display("Search wrap test done");
        for (int i = 0; i < 3; i++) begin
            fl = 4'($urandom_range(0, 9));
            wr(`REG_ERR_SRC_SEL, 8'h10 | 8'(1 << i));
            drive(1'b1, fl + 4'h2, '0);
            setup({fl + 4'h6, fl}, 8'h3e);
            wait_lock();
            repeat (3 * DWELL) @(negedge core_clk);
            check({search_locked, 3'h0, gain_setting}, {4'h8, fl + 4'h2});
            rd(`REG_ADAPTED_VALUE, rd_q);
            check(rd_q, {4'h8, fl + 4'h2});
            drive(1'b1, fl + 4'h2, link_err_s'(3'h4 >> i));
            wr(`REG_SEARCH_CTRL, 8'h3f);
            rd(`REG_ADAPTED_VALUE, rd_q);
            check(rd_q, {4'h0, fl});
            repeat (4 * DWELL + 8) @(negedge core_clk);
            check(8'(search_locked), 8'h0);
            drive(1'b1, fl + 4'h2, link_err_s'(3'h7 ^ (3'h4 >> i)));
            wait_lock();
            drive(1'b0, fl + 4'h2, '0);
            wait_change(n);
            check(8'(gain_setting), 8'(fl + 4'h3));
        end
        $display("Lock and error test done");
        finish_test();
    end
endmodule
